// File: logic/mdc_core.sv
// Execution datapath for data move, arithmetic and shift instructions
// Function
// - Signed range flag marks signed overflow
// - Zero flag set when result is zero
// - Carry flag on unsigned carry or borrow
// - Half carry flag on low nibble carry
// - Bit operand addresses limited to 0..0x3F
// - Load accumulator updates only zero flag
// - Immediate and store moves keep flags
// - Timer word read and load, flags kept
// - Indirect move through pointer, two cycles
// - Exchange accumulator with memory, flags kept
// - Save flags and accumulator, pointer plus two
// - Pointer minus two, restore flags and accumulator
// - Plain addition updates all four flags
// - Addition with carry updates all flags
// - Negate destination then add other operand
// - Subtraction via two's complement, all flags
// - Subtraction with borrow, all flags
// - Increment and decrement memory, all flags
// - Clear memory byte, flags kept
// - Zero fill shifts, bit out to carry
// - Rotates through carry, carry only changes
// - Nibble swap of accumulator, flags kept
// - Four flags held together as one byte
`timescale 1ns/1ns
`default_nettype none
module mdc_core
(
    input  wire logic                       I_REF_CLK,
    input  wire logic                       I_RST_N,
    input  wire logic                       I_VALID,
    input  wire mdc_pkg::mdc_op_e           I_OP,
    input  wire logic [mdc_pkg::DATA_W-1:0] I_IMM,
    input  wire logic [mdc_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [mdc_pkg::DATA_W-1:0] I_OPERAND,
    input  wire logic [mdc_pkg::WORD_W-1:0] I_WORD,
    input  wire logic [mdc_pkg::WORD_W-1:0] I_TIMER,
    input  wire logic [mdc_pkg::DATA_W-1:0] I_RD_DATA,
    input  wire logic                       I_SP_LOAD,
    input  wire logic [mdc_pkg::ADDR_W-1:0] I_SP_DATA,
    output logic                            O_BUSY,
    output logic                            O_DONE,
    output logic [mdc_pkg::DATA_W-1:0]      O_ACC,
    output logic [mdc_pkg::DATA_W-1:0]      O_FLAGS,
    output logic [mdc_pkg::ADDR_W-1:0]      O_STACK_POINTER,
    output logic                            O_WR_EN,
    output logic                            O_WR_IO,
    output logic                            O_WR_WORD,
    output logic [mdc_pkg::ADDR_W-1:0]      O_WR_ADDR,
    output logic [mdc_pkg::WORD_W-1:0]      O_WR_DATA,
    output logic                            O_RD_EN,
    output logic [mdc_pkg::ADDR_W-1:0]      O_RD_ADDR,
    output logic                            O_TMR_LOAD,
    output logic [mdc_pkg::WORD_W-1:0]      O_TMR_DATA,
    output logic                            O_BIT_ADDR_OK
);
    import mdc_pkg::*;

    mdc_regs_s         q;
    mdc_regs_s         d;

    logic [DATA_W-1:0] add_a;
    logic [DATA_W-1:0] add_b;
    logic              add_cin;
    logic              add_sub;
    logic              add_use;
    logic              add_to_acc;
    logic [DATA_W-1:0] add_sum;
    logic              add_carry;
    logic              add_half;
    logic              add_range;
    logic              take;

    assign take = I_VALID && (q.state == ST_IDLE);

    // Operand select for the adder
    always_comb
    begin
        add_a      = q.acc;
        add_b      = ZERO_BYTE;
        add_cin    = 1'b0;
        add_sub    = 1'b0;
        add_use    = 1'b1;
        add_to_acc = 1'b1;
        case (I_OP)
            OP_ADD_A_IMM: add_b = I_IMM;
            OP_ADD_A_M:   add_b = I_OPERAND;
            OP_ADD_M_A:
            begin
                add_b      = I_OPERAND;
                add_to_acc = 1'b0;
            end
            OP_ADDC_A_M:
            begin
                add_b   = I_OPERAND;
                add_cin = q.carry;
            end
            OP_ADDC_M_A:
            begin
                add_b      = I_OPERAND;
                add_cin    = q.carry;
                add_to_acc = 1'b0;
            end
            OP_ADDC_A:    add_cin = q.carry;
            OP_ADDC_M:
            begin
                add_a      = I_OPERAND;
                add_cin    = q.carry;
                add_to_acc = 1'b0;
            end
            OP_NADD_A_M:
            begin
                add_a   = I_OPERAND;
                add_b   = q.acc;
                add_sub = 1'b1;
            end
            OP_NADD_M_A:
            begin
                add_b      = I_OPERAND;
                add_sub    = 1'b1;
                add_to_acc = 1'b0;
            end
            OP_SUB_A_IMM:
            begin
                add_b   = I_IMM;
                add_sub = 1'b1;
            end
            OP_SUB_A_M:
            begin
                add_b   = I_OPERAND;
                add_sub = 1'b1;
            end
            OP_SUB_M_A:
            begin
                add_a      = I_OPERAND;
                add_b      = q.acc;
                add_sub    = 1'b1;
                add_to_acc = 1'b0;
            end
            OP_SUBC_A_M:
            begin
                add_b   = I_OPERAND;
                add_cin = q.carry;
                add_sub = 1'b1;
            end
            OP_SUBC_M_A:
            begin
                add_a      = I_OPERAND;
                add_b      = q.acc;
                add_cin    = q.carry;
                add_sub    = 1'b1;
                add_to_acc = 1'b0;
            end
            OP_SUBC_A:
            begin
                add_cin = q.carry;
                add_sub = 1'b1;
            end
            OP_SUBC_M:
            begin
                add_a      = I_OPERAND;
                add_cin    = q.carry;
                add_sub    = 1'b1;
                add_to_acc = 1'b0;
            end
            OP_INC_M:
            begin
                add_a      = I_OPERAND;
                add_b      = ONE_BYTE;
                add_to_acc = 1'b0;
            end
            OP_DEC_M:
            begin
                add_a      = I_OPERAND;
                add_b      = ONE_BYTE;
                add_sub    = 1'b1;
                add_to_acc = 1'b0;
            end
            default:
            begin
                add_use    = 1'b0;
                add_to_acc = 1'b0;
            end
        endcase
    end

    mdc_adder u_adder
    (
        .i_a     (add_a),
        .i_b     (add_b),
        .i_cin   (add_cin),
        .i_sub   (add_sub),
        .o_sum   (add_sum),
        .o_carry (add_carry),
        .o_half  (add_half),
        .o_range (add_range)
    );

    // Next state of all registers
    always_comb
    begin
        d         = q;
        d.wr_en   = 1'b0;
        d.wr_io   = 1'b0;
        d.wr_word = 1'b0;
        d.rd_en   = 1'b0;
        d.tmr_ld  = 1'b0;
        d.done    = 1'b0;
        d.bit_ok  = (I_ADDR <= BIT_ADDR_MAX);
        if (I_SP_LOAD)
        begin
            d.stack_pointer = I_SP_DATA;
        end
        case (q.state)
            ST_IND_RD:
            begin
                d.acc   = I_RD_DATA;
                d.state = ST_IDLE;
                d.done  = 1'b1;
            end
            ST_IND_WR:
            begin
                d.wr_en   = 1'b1;
                d.wr_addr = q.ptr;
                d.wr_data = {8'h00, q.acc};
                d.state   = ST_IDLE;
                d.done    = 1'b1;
            end
            ST_IDLE:
            begin
                if (take)
                begin
                    d.done = 1'b1;
                    d.wr_addr = I_ADDR;
                    if (add_use)
                    begin
                        d.zero         = (add_sum == ZERO_BYTE);
                        d.carry        = add_carry;
                        d.half_carry   = add_half;
                        d.signed_range = add_range;
                        if (add_to_acc)
                        begin
                            d.acc = add_sum;
                        end
                        else
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_data = {8'h00, add_sum};
                        end
                    end
                    case (I_OP)
                        OP_MOV_A_IMM: d.acc = I_IMM;
                        OP_MOV_M_A, OP_MOV_IO_A:
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_io   = (I_OP == OP_MOV_IO_A);
                            d.wr_data = {8'h00, q.acc};
                        end
                        OP_MOV_A_M, OP_MOV_A_IO:
                        begin
                            d.acc  = I_OPERAND;
                            d.zero = (I_OPERAND == ZERO_BYTE);
                        end
                        OP_TIMER_READ:
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_word = 1'b1;
                            d.wr_data = I_TIMER;
                        end
                        OP_TIMER_LOAD:
                        begin
                            d.tmr_ld   = 1'b1;
                            d.tmr_data = I_WORD;
                        end
                        OP_IDX_READ:
                        begin
                            d.ptr   = I_WORD[ADDR_W-1:0];
                            d.rd_en = 1'b1;
                            d.state = ST_IND_RD;
                            d.done  = 1'b0;
                        end
                        OP_IDX_WRITE:
                        begin
                            d.ptr   = I_WORD[ADDR_W-1:0];
                            d.state = ST_IND_WR;
                            d.done  = 1'b0;
                        end
                        OP_XCH_M:
                        begin
                            d.acc     = I_OPERAND;
                            d.wr_en   = 1'b1;
                            d.wr_data = {8'h00, q.acc};
                        end
                        OP_SAVE_AF:
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_word = 1'b1;
                            d.wr_addr = q.stack_pointer;
                            d.wr_data = {O_FLAGS, q.acc};
                            d.stack_pointer = q.stack_pointer + STACK_STEP;
                        end
                        OP_RESTORE_AF:
                        begin
                            d.stack_pointer = q.stack_pointer - STACK_STEP;
                            d.acc           = I_WORD[7:0];
                            d.zero          = I_WORD[8+FLAG_ZERO_BIT];
                            d.carry         = I_WORD[8+FLAG_CARRY_BIT];
                            d.half_carry    = I_WORD[8+FLAG_HALF_BIT];
                            d.signed_range  = I_WORD[8+FLAG_RANGE_BIT];
                        end
                        OP_CLEAR_M:
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_data = 16'h0000;
                        end
                        OP_SHIFT_RIGHT_A, OP_ROT_RIGHT_A:
                        begin
                            d.acc   = {(I_OP == OP_ROT_RIGHT_A) && q.carry, q.acc[7:1]};
                            d.carry = q.acc[0];
                        end
                        OP_SHIFT_LEFT_A, OP_ROT_LEFT_A:
                        begin
                            d.acc   = {q.acc[6:0], (I_OP == OP_ROT_LEFT_A) && q.carry};
                            d.carry = q.acc[7];
                        end
                        OP_SHIFT_RIGHT_M, OP_ROT_RIGHT_M:
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_data = {8'h00, (I_OP == OP_ROT_RIGHT_M) && q.carry,
                                         I_OPERAND[7:1]};
                            d.carry   = I_OPERAND[0];
                        end
                        OP_SHIFT_LEFT_M, OP_ROT_LEFT_M:
                        begin
                            d.wr_en   = 1'b1;
                            d.wr_data = {8'h00, I_OPERAND[6:0],
                                         (I_OP == OP_ROT_LEFT_M) && q.carry};
                            d.carry   = I_OPERAND[7];
                        end
                        OP_NIBBLE_SWAP_A: d.acc = {q.acc[3:0], q.acc[7:4]};
                        default: ;
                    endcase
                end
            end
            default: d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            q <= REGS_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // Flag byte assembled from flip-flops only
    always_comb
    begin
        O_FLAGS                 = 8'h00;
        O_FLAGS[FLAG_ZERO_BIT]  = q.zero;
        O_FLAGS[FLAG_CARRY_BIT] = q.carry;
        O_FLAGS[FLAG_HALF_BIT]  = q.half_carry;
        O_FLAGS[FLAG_RANGE_BIT] = q.signed_range;
    end

    assign O_BUSY          = (q.state != ST_IDLE);
    assign O_DONE          = q.done;
    assign O_ACC           = q.acc;
    assign O_STACK_POINTER = q.stack_pointer;
    assign O_WR_EN         = q.wr_en;
    assign O_WR_IO         = q.wr_io;
    assign O_WR_WORD       = q.wr_word;
    assign O_WR_ADDR       = q.wr_addr;
    assign O_WR_DATA       = q.wr_data;
    assign O_RD_EN         = q.rd_en;
    assign O_RD_ADDR       = q.ptr;
    assign O_TMR_LOAD      = q.tmr_ld;
    assign O_TMR_DATA      = q.tmr_data;
    assign O_BIT_ADDR_OK   = q.bit_ok;
endmodule : mdc_core
`default_nettype wire

// File: logic/mdc_pkg.sv
// Shared constants, operation codes and state layout for the data move, arithmetic and shift core
package mdc_pkg;

    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned WORD_W       = 16;

    localparam logic [ADDR_W-1:0] BIT_ADDR_MAX = 8'h3f;
    localparam logic [ADDR_W-1:0] STACK_STEP   = 8'h02;
    localparam logic [ADDR_W-1:0] STACK_RST    = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RST      = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE     = 8'h01;
    localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;

    // Flag byte layout
    localparam int unsigned FLAG_ZERO_BIT  = 0;
    localparam int unsigned FLAG_CARRY_BIT = 1;
    localparam int unsigned FLAG_HALF_BIT  = 2;
    localparam int unsigned FLAG_RANGE_BIT = 3;

    typedef enum logic [5:0] {
        OP_NOP            = 6'h00,
        OP_MOV_A_IMM      = 6'h01,
        OP_MOV_M_A        = 6'h02,
        OP_MOV_A_M        = 6'h03,
        OP_MOV_A_IO       = 6'h04,
        OP_MOV_IO_A       = 6'h05,
        OP_TIMER_READ     = 6'h06,
        OP_TIMER_LOAD     = 6'h07,
        OP_IDX_READ       = 6'h08,
        OP_IDX_WRITE      = 6'h09,
        OP_XCH_M          = 6'h0a,
        OP_SAVE_AF        = 6'h0b,
        OP_RESTORE_AF     = 6'h0c,
        OP_ADD_A_IMM      = 6'h0d,
        OP_ADD_A_M        = 6'h0e,
        OP_ADD_M_A        = 6'h0f,
        OP_ADDC_A_M       = 6'h10,
        OP_ADDC_M_A       = 6'h11,
        OP_ADDC_A         = 6'h12,
        OP_ADDC_M         = 6'h13,
        OP_NADD_A_M       = 6'h14,
        OP_NADD_M_A       = 6'h15,
        OP_SUB_A_IMM      = 6'h16,
        OP_SUB_A_M        = 6'h17,
        OP_SUB_M_A        = 6'h18,
        OP_SUBC_A_M       = 6'h19,
        OP_SUBC_M_A       = 6'h1a,
        OP_SUBC_A         = 6'h1b,
        OP_SUBC_M         = 6'h1c,
        OP_INC_M          = 6'h1d,
        OP_DEC_M          = 6'h1e,
        OP_CLEAR_M        = 6'h1f,
        OP_SHIFT_RIGHT_A  = 6'h20,
        OP_ROT_RIGHT_A    = 6'h21,
        OP_SHIFT_RIGHT_M  = 6'h22,
        OP_ROT_RIGHT_M    = 6'h23,
        OP_SHIFT_LEFT_A   = 6'h24,
        OP_ROT_LEFT_A     = 6'h25,
        OP_SHIFT_LEFT_M   = 6'h26,
        OP_ROT_LEFT_M     = 6'h27,
        OP_NIBBLE_SWAP_A  = 6'h28
    } mdc_op_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_IND_RD = 3'b010,
        ST_IND_WR = 3'b100
    } mdc_state_e;

    typedef struct packed {
        mdc_state_e          state;
        logic [DATA_W-1:0]   acc;
        logic                zero;
        logic                carry;
        logic                half_carry;
        logic                signed_range;
        logic [ADDR_W-1:0]   stack_pointer;
        logic [ADDR_W-1:0]   ptr;
        logic                wr_en;
        logic                wr_io;
        logic                wr_word;
        logic [ADDR_W-1:0]   wr_addr;
        logic [WORD_W-1:0]   wr_data;
        logic                rd_en;
        logic                tmr_ld;
        logic [WORD_W-1:0]   tmr_data;
        logic                bit_ok;
        logic                done;
    } mdc_regs_s;

    localparam mdc_regs_s REGS_RST = '{
        state:         ST_IDLE,
        acc:           ACC_RST,
        zero:          1'b0,
        carry:         1'b0,
        half_carry:    1'b0,
        signed_range:  1'b0,
        stack_pointer: STACK_RST,
        ptr:           8'h00,
        wr_en:         1'b0,
        wr_io:         1'b0,
        wr_word:       1'b0,
        wr_addr:       8'h00,
        wr_data:       16'h0000,
        rd_en:         1'b0,
        tmr_ld:        1'b0,
        tmr_data:      16'h0000,
        bit_ok:        1'b0,
        done:          1'b0
    };

endpackage : mdc_pkg

// File: logic/mdc_adder.sv
// Eight-bit adder and subtracter with carry, half carry and signed range results
`timescale 1ns/1ns
`default_nettype none
module mdc_adder
(
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_cin,
    input  wire logic       i_sub,
    output wire logic [7:0] o_sum,
    output wire logic       o_carry,
    output wire logic       o_half,
    output wire logic       o_range
);
    logic [7:0] bx;
    logic       cx;
    logic [8:0] full;
    logic [4:0] low;

    // Subtraction adds the two's complement; carry in is an inverted borrow
    assign bx      = i_sub ? ~i_b : i_b;
    assign cx      = i_sub ? ~i_cin : i_cin;
    assign full    = {1'b0, i_a} + {1'b0, bx} + {8'h00, cx};
    assign low     = {1'b0, i_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
    assign o_sum   = full[7:0];
    assign o_carry = full[8] ^ i_sub;
    assign o_half  = low[4] ^ i_sub;
    assign o_range = (i_a[7] == bx[7]) && (full[7] != i_a[7]);
endmodule : mdc_adder
`default_nettype wire

// File: bench/mdc_mem.sv
// Partner model: data memory, IO space and wide timer
`timescale 1ns/1ns
`default_nettype none
module mdc_mem
(
    input  wire logic        I_REF_CLK, I_RST_N, O_WR_EN, O_WR_IO, O_WR_WORD, O_RD_EN, O_TMR_LOAD,
    input  wire logic [7:0]  O_WR_ADDR, O_RD_ADDR,
    input  wire logic [15:0] O_WR_DATA, O_TMR_DATA,
    output logic [7:0]       I_RD_DATA,
    output logic [15:0]      I_TIMER
);
    logic [7:0] mem [256];
    logic [7:0] io [256];
    initial
    for (int i = 0; i < 256; i++)
    begin
        mem[i] = 8'(i * 37 + 5);
        io[i] = 8'(i * 11);
    end
    // Read data is only valid while requested
    assign I_RD_DATA = O_RD_EN ? mem[O_RD_ADDR] : ~mem[O_RD_ADDR];
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
        if (!I_RST_N)
            I_TIMER <= 16'h0000;
        else
            I_TIMER <= O_TMR_LOAD ? O_TMR_DATA : I_TIMER + 16'h0001;
    always @(posedge I_REF_CLK)
        if (O_WR_EN && O_WR_IO)
            io[O_WR_ADDR] <= O_WR_DATA[7:0];
        else if (O_WR_EN)
        begin
            mem[O_WR_ADDR] <= O_WR_DATA[7:0];
            if (O_WR_WORD)
                mem[O_WR_ADDR + 8'h01] <= O_WR_DATA[15:8];
        end
endmodule : mdc_mem
`default_nettype wire

// File: bench/mdc_core_sva.sv
// Concurrent checks on the core ports
`timescale 1ns/1ns
`default_nettype none
module mdc_core_sva
(
    input wire logic        I_REF_CLK, I_RST_N, I_VALID, O_BUSY, O_DONE, O_WR_EN, O_WR_WORD,
    input wire logic        O_BIT_ADDR_OK, O_RD_EN,
    input wire mdc_pkg::mdc_op_e I_OP,
    input wire logic [7:0]  I_ADDR, I_OPERAND, O_ACC, O_FLAGS, O_STACK_POINTER, O_WR_ADDR,
    input wire logic [15:0] I_WORD, O_WR_DATA
);
    import mdc_pkg::*;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    logic tk, idx;
    assign tk = I_VALID && !O_BUSY;
    assign idx = I_OP inside {OP_IDX_READ, OP_IDX_WRITE};
    AST_ONE_CYCLE: assert property (tk && !idx |=> O_DONE && !O_BUSY)
        else $error("late completion");
    AST_TWO_CYCLE: assert property (tk && idx |=> O_BUSY && !O_DONE ##1 O_DONE && !O_BUSY)
        else $error("indirect move timing");
    AST_SAVE: assert property (tk && I_OP == OP_SAVE_AF |=> O_WR_EN && O_WR_WORD
        && O_WR_DATA == {$past(O_FLAGS), $past(O_ACC)} && O_WR_ADDR == $past(O_STACK_POINTER)
        && O_STACK_POINTER == $past(O_STACK_POINTER) + 8'h02) else $error("save");
    AST_RESTORE: assert property (tk && I_OP == OP_RESTORE_AF |=> O_FLAGS[3:0] == $past(I_WORD[11:8])
        && O_STACK_POINTER == $past(O_STACK_POINTER) - 8'h02) else $error("restore");
    AST_LOAD: assert property (tk && I_OP inside {OP_MOV_A_M, OP_MOV_A_IO} |=> O_ACC == $past(I_OPERAND)
        && O_FLAGS[3:1] == $past(O_FLAGS[3:1]) && O_FLAGS[0] == ($past(I_OPERAND) == 8'h00))
        else $error("load");
    AST_KEEP: assert property (tk && I_OP inside {[OP_MOV_A_IMM:OP_SAVE_AF], OP_CLEAR_M,
        OP_NIBBLE_SWAP_A} && !(I_OP inside {OP_MOV_A_M, OP_MOV_A_IO}) |=> $stable(O_FLAGS))
        else $error("flags moved");
    AST_SHIFT: assert property (tk && I_OP inside {[OP_SHIFT_RIGHT_A:OP_ROT_LEFT_M]} |=>
        O_FLAGS[0] == $past(O_FLAGS[0]) && O_FLAGS[3:2] == $past(O_FLAGS[3:2])) else $error("shift");
    AST_BIT_ADDR: assert property ($past(I_RST_N) |-> O_BIT_ADDR_OK == ($past(I_ADDR) <= 8'h3f))
        else $error("bit address");
    COV_IDX: cover property (tk && I_OP == OP_IDX_READ ##1 O_RD_EN);
    COV_SAVE: cover property (tk && I_OP == OP_SAVE_AF);
    COV_RESTORE: cover property (tk && I_OP == OP_RESTORE_AF);
endmodule : mdc_core_sva
bind mdc_core mdc_core_sva mdc_core_sva_inst (.*);
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench for the core
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mdc_pkg::*;
    logic I_REF_CLK = 1'b0, I_RST_N = 1'b0, I_VALID = 1'b0, I_SP_LOAD = 1'b0;
    mdc_op_e I_OP = OP_NOP;
    logic [7:0] I_IMM = 8'h00, I_ADDR = 8'h00, I_OPERAND = 8'h00, I_SP_DATA = 8'h00, I_RD_DATA;
    logic [15:0] I_WORD = 16'h0000, I_TIMER, O_WR_DATA, O_TMR_DATA, wd;
    logic O_BUSY, O_DONE, O_WR_EN, O_WR_IO, O_WR_WORD, O_RD_EN, O_TMR_LOAD, O_BIT_ADDR_OK;
    logic [7:0] O_ACC, O_FLAGS, O_STACK_POINTER, O_WR_ADDR, O_RD_ADDR, acc_e, sp_e, x, y, wa, m;
    logic [3:0] f;
    logic [11:0] r;
    logic s, k, dm, ar, we, wio, ww, tl;
    int bad_count = 0, tests_run = 0;
    mdc_core mdc_core_inst (.*);
    mdc_mem mdc_mem_inst (.*);
    always #10 I_REF_CLK = ~I_REF_CLK;
    function automatic logic [11:0] alu(input logic [7:0] a, b, input logic sb, cy);
        logic [8:0] t;
        logic hc;
        t = sb ? {1'b0, a} - {1'b0, b} - 9'(cy) : {1'b0, a} + {1'b0, b} + 9'(cy);
        hc = sb ? {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(cy) : {1'b0, a[3:0]} + b[3:0] + 5'(cy) > 5'h0f;
        return {(a[7] ^ t[7]) & (a[7] ^ b[7] ^ !sb), hc, t[8], t[7:0] == 8'h00, t[7:0]};
    endfunction : alu
    task chk(input string n, input logic [15:0] sn, ex);
        tests_run++;
        if (sn !== ex)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, ex, sn);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task run(input mdc_op_e op, input logic [7:0] im, ad, input logic [15:0] w, input logic spl);
        m = (op == OP_MOV_A_IO) ? mdc_mem_inst.io[ad] : mdc_mem_inst.mem[ad];
        if (op == OP_RESTORE_AF)
            w = {mdc_mem_inst.mem[sp_e - 8'h01], mdc_mem_inst.mem[sp_e - 8'h02]};
        spl = spl && !(op inside {[OP_IDX_READ:OP_RESTORE_AF]});
        {I_VALID, I_OP, I_IMM, I_ADDR, I_OPERAND, I_WORD} = {1'b1, op, im, ad, m, w};
        {I_SP_LOAD, I_SP_DATA} = {spl, w[15:8]};
        {we, wio, ww, tl, ar, s, k, dm, wa, wd, x, y} = {8'h00, ad, 8'h00, acc_e, acc_e, m};
        if (spl)
            sp_e = w[15:8];
        case (op)
            OP_MOV_A_IMM: acc_e = im;
            OP_MOV_M_A, OP_CLEAR_M: {we, wd} = {1'b1, 8'h00, op == OP_CLEAR_M ? 8'h00 : acc_e};
            OP_MOV_IO_A: {we, wio} = 2'b11;
            OP_MOV_A_M, OP_MOV_A_IO: {acc_e, f[0]} = {m, m == 8'h00};
            OP_TIMER_READ: {we, ww, wd} = {2'b11, I_TIMER};
            OP_TIMER_LOAD: tl = 1'b1;
            OP_IDX_READ: acc_e = mdc_mem_inst.mem[w[7:0]];
            OP_IDX_WRITE: {we, wa} = {1'b1, w[7:0]};
            OP_XCH_M: {we, acc_e} = {1'b1, m};
            OP_SAVE_AF: {we, ww, wa, wd, sp_e} = {2'b11, sp_e, 4'h0, f, acc_e, sp_e + 8'h02};
            OP_RESTORE_AF: {sp_e, f, acc_e} = {sp_e - 8'h02, w[11:8], w[7:0]};
            OP_NIBBLE_SWAP_A: acc_e = {acc_e[3:0], acc_e[7:4]};
            OP_ADD_A_IMM, OP_SUB_A_IMM: {ar, s, y} = {1'b1, op == OP_SUB_A_IMM, im};
            OP_ADD_A_M, OP_ADD_M_A: {ar, dm} = {1'b1, op == OP_ADD_M_A};
            OP_ADDC_A_M, OP_ADDC_M_A: {ar, dm, k} = {1'b1, op == OP_ADDC_M_A, f[1]};
            OP_ADDC_A, OP_SUBC_A: {ar, s, y, k} = {1'b1, op == OP_SUBC_A, 8'h00, f[1]};
            OP_ADDC_M, OP_SUBC_M: {ar, s, dm, x, y, k} = {1'b1, op == OP_SUBC_M, 1'b1, m, 8'h00, f[1]};
            OP_NADD_A_M, OP_SUB_M_A: {ar, s, dm, x, y} = {2'b11, op == OP_SUB_M_A, m, acc_e};
            OP_NADD_M_A, OP_SUB_A_M: {ar, s, dm} = {2'b11, op == OP_NADD_M_A};
            OP_SUBC_A_M: {ar, s, k} = {2'b11, f[1]};
            OP_SUBC_M_A: {ar, s, dm, x, y, k} = {3'b111, m, acc_e, f[1]};
            OP_INC_M, OP_DEC_M: {ar, s, dm, x, y} = {1'b1, op == OP_DEC_M, 1'b1, m, 8'h01};
            default:
                if (op inside {[OP_SHIFT_RIGHT_A:OP_ROT_LEFT_M]})
                begin
                    x = op[1] ? m : acc_e;
                    y = op[2] ? {x[6:0], op[0] & f[1]} : {op[0] & f[1], x[7:1]};
                    f[1] = op[2] ? x[7] : x[0];
                    {we, wd} = {op[1], 8'h00, y};
                    acc_e = op[1] ? acc_e : y;
                end
        endcase
        if (ar)
        begin
            r = alu(x, y, s, k);
            {f, we, wd} = {r[11:8], dm, 8'h00, r[7:0]};
            acc_e = dm ? acc_e : r[7:0];
        end
        @(posedge I_REF_CLK);
        #1;
        if (op inside {OP_IDX_READ, OP_IDX_WRITE})
        begin
            chk("busy and read", {O_BUSY, O_RD_EN}, {1'b1, op == OP_IDX_READ});
            chk("rd addr", O_RD_ADDR, w[7:0]);
            if (op == OP_IDX_READ)
                acc_e = mdc_mem_inst.mem[w[7:0]];
            @(posedge I_REF_CLK);
            #1;
        end
        chk("done", O_DONE, 1'b1);
        chk("acc", O_ACC, acc_e);
        chk("flags", O_FLAGS, {4'h0, f});
        chk("stack", O_STACK_POINTER, sp_e);
        chk("bit addr", O_BIT_ADDR_OK, ad <= 8'h3f);
        chk("strobes", {O_WR_EN, O_TMR_LOAD}, {we, tl});
        if (tl)
            chk("timer data", O_TMR_DATA, w);
        if (we)
            chk("wr data", O_WR_DATA, wd);
        if (we)
            chk("wr ctl", {O_WR_IO, O_WR_WORD, O_WR_ADDR}, {wio, ww, wa});
    endtask : run
    initial
    begin
        #100000;
        bad_count++;
        finish_test;
    end
    initial
    begin
        void'($urandom(32'he2cdf58d));
        {acc_e, f, sp_e} = 20'h00000;
        repeat (16) @(posedge I_REF_CLK);
        #1;
        I_RST_N = 1'b1;
        run(OP_MOV_A_IMM, 8'h7f, 8'h3f, 16'h0000, 1'b0);
        run(OP_ADD_A_IMM, 8'h01, 8'h40, 16'h0000, 1'b0);
        run(OP_SUB_A_IMM, 8'h81, 8'h00, 16'h0000, 1'b0);
        run(OP_ADDC_A, 8'h00, 8'hff, 16'h0000, 1'b0);
        for (int i = 0; i <= 40; i++)
            run(mdc_op_e'(i), 8'($urandom), 8'($urandom), 16'($urandom), 1'b0);
        $display("sweep of all operations done");
        repeat (1500)
            run(mdc_op_e'($urandom_range(40)), 8'($urandom), 8'($urandom), 16'($urandom),
                $urandom_range(7) == 0);
        $display("random operations done");
        I_VALID = 1'b0;
        finish_test;
    end
endmodule : tb
`default_nettype wire
